/* File: ahb_reg_port.sv */
// ahb-lite slave front end: zero wait states, registered read data
`timescale 1ns/10ps
`include "pend_set_consts.svh"

module ahb_reg_port
  import pend_set_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // ahb-lite slave side
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic                  hready_i,
  input  wire logic [`WORD_BITS-1:0] hwdata_i,
  output logic      [`WORD_BITS-1:0] hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  // register side
  output reg_wr_t                    wr_o,
  output reg_rd_t                    rd_o,
  input  wire logic [`WORD_BITS-1:0] rd_data_i
);

  logic                  wr_pend;
  logic [`ADDR_BITS-1:0] wr_addr;

  // only whole-word transfers touch the registers; others complete quietly
  wire addr_ok = hsel_i && hready_i && htrans_i == `HTRANS_NONSEQ
                 && hsize_i == `HSIZE_WORD;

  assign rd_o.valid  = addr_ok && !hwrite_i;
  assign rd_o.addr   = haddr_i[`ADDR_BITS-1:0];
  assign wr_o.valid  = wr_pend;
  assign wr_o.addr   = wr_addr;
  assign wr_o.data   = hwdata_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = `HRESP_OKAY;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_pend  <= 1'b0;
      wr_addr  <= '0;
      hrdata_o <= `RDATA_RESET;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite_i;
      wr_addr <= haddr_i[`ADDR_BITS-1:0];
      if (rd_o.valid)
        hrdata_o <= rd_data_i;
    end
  end

endmodule : ahb_reg_port

/* File: interrupt_pend_set_upper.sv */
// pending-set logic for interrupts 32 to 77 with its register window
`timescale 1ns/10ps
`include "pend_set_consts.svh"

module interrupt_pend_set_upper
  import pend_set_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // ahb-lite register bus
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic                  hready_i,
  input  wire logic [`WORD_BITS-1:0] hwdata_i,
  output logic      [`WORD_BITS-1:0] hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  // interrupt sources and core status, bit k is interrupt 32+k
  input  wire logic [`ALL_BITS-1:0]  irq_i,
  input  wire logic [`ALL_BITS-1:0]  active_i,
  // state towards the priority logic
  output logic      [`ALL_BITS-1:0]  pending_o,
  output logic      [`ALL_BITS-1:0]  enabled_o
);

  reg_wr_t wr;
  reg_rd_t rd;

  function automatic logic hit(input logic [`ADDR_BITS-1:0] a,
                               input logic [`ADDR_BITS-1:0] off);
    hit = (a == off);
  endfunction : hit

  // write strobes
  wire wr_ps_mid  = wr.valid && hit(wr.addr, `OFF_PS_MID);
  wire wr_ps_high = wr.valid && hit(wr.addr, `OFF_PS_HIGH);
  wire wr_pc_mid  = wr.valid && hit(wr.addr, `OFF_PC_MID);
  wire wr_pc_high = wr.valid && hit(wr.addr, `OFF_PC_HIGH);
  wire wr_es_mid  = wr.valid && hit(wr.addr, `OFF_ES_MID);
  wire wr_es_high = wr.valid && hit(wr.addr, `OFF_ES_HIGH);
  wire wr_ec_mid  = wr.valid && hit(wr.addr, `OFF_EC_MID);
  wire wr_ec_high = wr.valid && hit(wr.addr, `OFF_EC_HIGH);

  wire [`MID_BITS-1:0]  wd_mid  = wr.data[`MID_BITS-1:0];
  wire [`HIGH_BITS-1:0] wd_high = wr.data[`HIGH_BITS-1:0];

  // a write of zero yields an all-zero request vector, so nothing moves
  wire [`MID_BITS-1:0]  set_mid  = wr_ps_mid  ? wd_mid  : '0;
  wire [`HIGH_BITS-1:0] set_high = wr_ps_high ? wd_high : '0;
  wire [`MID_BITS-1:0]  clr_mid  = wr_pc_mid  ? wd_mid  : '0;
  wire [`HIGH_BITS-1:0] clr_high = wr_pc_high ? wd_high : '0;
  wire [`MID_BITS-1:0]  ens_mid  = wr_es_mid  ? wd_mid  : '0;
  wire [`HIGH_BITS-1:0] ens_high = wr_es_high ? wd_high : '0;
  wire [`MID_BITS-1:0]  enc_mid  = wr_ec_mid  ? wd_mid  : '0;
  wire [`HIGH_BITS-1:0] enc_high = wr_ec_high ? wd_high : '0;

  wire [`MID_BITS-1:0]  pend_mid;
  wire [`HIGH_BITS-1:0] pend_high;
  wire [`MID_BITS-1:0]  en_mid;
  wire [`HIGH_BITS-1:0] en_high;

  wire [`MID_BITS-1:0]  irq_mid   = irq_i[`MID_BITS-1:0];
  wire [`HIGH_BITS-1:0] irq_high  = irq_i[`ALL_BITS-1:`MID_BITS];
  wire [`MID_BITS-1:0]  act_mid   = active_i[`MID_BITS-1:0];
  wire [`HIGH_BITS-1:0] act_high  = active_i[`ALL_BITS-1:`MID_BITS];

  assign pending_o = {pend_high, pend_mid};
  assign enabled_o = {en_high, en_mid};

  // read mux: both pend words show pending, both enable words show enable
  wire [`WORD_BITS-1:0] high_pend_word =
    {{(`WORD_BITS-`HIGH_BITS){1'b0}}, pend_high};
  wire [`WORD_BITS-1:0] high_en_word =
    {{(`WORD_BITS-`HIGH_BITS){1'b0}}, en_high};
  wire rd_pend_mid  = hit(rd.addr, `OFF_PS_MID)
                      || hit(rd.addr, `OFF_PC_MID);
  wire rd_pend_high = hit(rd.addr, `OFF_PS_HIGH)
                      || hit(rd.addr, `OFF_PC_HIGH);
  wire rd_en_mid    = hit(rd.addr, `OFF_ES_MID)
                      || hit(rd.addr, `OFF_EC_MID);
  wire rd_en_high   = hit(rd.addr, `OFF_ES_HIGH)
                      || hit(rd.addr, `OFF_EC_HIGH);
  logic [`WORD_BITS-1:0] rd_data;

  always_comb
  begin
    if (rd_pend_mid)
      rd_data = pend_mid;
    else if (rd_pend_high)
      rd_data = high_pend_word;
    else if (rd_en_mid)
      rd_data = en_mid;
    else if (rd_en_high)
      rd_data = high_en_word;
    else
      rd_data = '0;
  end

  ahb_reg_port u_port (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hready_i    (hready_i),
    .hwdata_i    (hwdata_i),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .wr_o        (wr),
    .rd_o        (rd),
    .rd_data_i   (rd_data)
  );

  // the banks hold the enable gate, the serviced guard and set priority
  pend_bank #(.W(`MID_BITS)) u_mid (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .hw_set_i (irq_mid),
    .sw_set_i (set_mid),
    .sw_clr_i (clr_mid),
    .en_set_i (ens_mid),
    .en_clr_i (enc_mid),
    .active_i (act_mid),
    .pend_o   (pend_mid),
    .en_o     (en_mid)
  );

  pend_bank #(.W(`HIGH_BITS)) u_high (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .hw_set_i (irq_high),
    .sw_set_i (set_high),
    .sw_clr_i (clr_high),
    .en_set_i (ens_high),
    .en_clr_i (enc_high),
    .active_i (act_high),
    .pend_o   (pend_high),
    .en_o     (en_high)
  );

  // checks

  wire rd_ps_mid  = rd.valid && hit(rd.addr, `OFF_PS_MID);
  wire rd_ps_high = rd.valid && hit(rd.addr, `OFF_PS_HIGH);
  wire rd_pc_mid  = rd.valid && hit(rd.addr, `OFF_PC_MID);
  wire rd_pc_high = rd.valid && hit(rd.addr, `OFF_PC_HIGH);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_irq_map: assert property (
    (|irq_i) |=> ((pending_o & $past(irq_i)) == $past(irq_i)))
    else $error("hardware request did not reach its pending bit");

  chk_high_zero: assert property (
    rd_ps_high |=> (hrdata_o[`WORD_BITS-1:`HIGH_BITS] == '0
                    && hrdata_o[`HIGH_BITS-1:0] == $past(pend_high)))
    else $error("high pend word read back wrong");

  chk_set_lands: assert property (
    wr_ps_mid |=>
      ((pend_mid & $past(wd_mid & en_mid)) == $past(wd_mid & en_mid)))
    else $error("pend write on enabled line did not set it");

  chk_set_blocked: assert property (
    ##1 ((pend_mid & ~$past(pend_mid) & ~$past(irq_mid)
          & ~$past(en_mid)) == '0))
    else $error("disabled line became pending by software");

  chk_zero_keeps: assert property (
    (!wr_pc_mid && !wr_pc_high) |=>
      (($past(pending_o) & ~pending_o) == '0))
    else $error("pending bit dropped without a clear write");

  chk_read_live: assert property (
    rd_ps_mid |=> (hrdata_o == $past(pend_mid)))
    else $error("mid pend word read did not return pending state");

  chk_clear_works: assert property (
    wr_pc_mid |=>
      ((pend_mid & $past(wd_mid & ~act_mid & ~irq_mid)) == '0))
    else $error("clear-pending write left a bit set");

  chk_active_kept: assert property (
    wr_pc_high |=>
      ((pend_high & $past(wd_high & act_high & pend_high))
       == $past(wd_high & act_high & pend_high)))
    else $error("serviced interrupt lost its pending bit");

  // the blocking of later pend writes is watched by the two blocked checks
  chk_clren_blocks: assert property (
    wr_ec_high |=> ((en_high & $past(wd_high)) == '0))
    else $error("clear-enable write left a line enabled");

  chk_high_blocked: assert property (
    ##1 ((pend_high & ~$past(pend_high) & ~$past(irq_high)
          & ~$past(en_high)) == '0))
    else $error("disabled high line became pending by software");

  chk_high_set: assert property (
    wr_ps_high |=>
      ((pend_high & $past(wd_high & en_high)) == $past(wd_high & en_high)))
    else $error("high pend write on enabled line did not set it");

  chk_high_clear: assert property (
    wr_pc_high |=>
      ((pend_high & $past(wd_high & ~act_high & ~irq_high)) == '0))
    else $error("high clear-pending write left a bit set");

  chk_mid_active: assert property (
    wr_pc_mid |=>
      ((pend_mid & $past(wd_mid & act_mid & pend_mid))
       == $past(wd_mid & act_mid & pend_mid)))
    else $error("serviced mid interrupt lost its pending bit");

  chk_zero_set: assert property (
    (wr_ps_mid && wd_mid == '0) |=>
      (pend_mid == ($past(pend_mid) | $past(irq_mid))))
    else $error("zero pend write changed the pending state");

  chk_pend_steady: assert property (
    (!wr.valid && !(|irq_i)) |=> (pending_o == $past(pending_o)))
    else $error("pending state moved with no write and no request");

  chk_pc_mid_read: assert property (
    rd_pc_mid |=> (hrdata_o == $past(pend_mid)))
    else $error("mid clear word read did not return pending state");

  chk_pc_high_read: assert property (
    rd_pc_high |=> (hrdata_o[`WORD_BITS-1:`HIGH_BITS] == '0
                    && hrdata_o[`HIGH_BITS-1:0] == $past(pend_high)))
    else $error("high clear word read did not return pending state");

  chk_reset_clear: assert property (
    @(posedge clk_i) disable iff (1'b0)
    $fell(rst_i) |-> (pending_o == '0 && enabled_o == '0))
    else $error("flags not cleared by reset");

  cov_sw_pend: cover property (
    wr_ps_mid && (wd_mid & en_mid & ~pend_mid) != '0);
  cov_clr_blocked: cover property (
    wr_pc_high && (wd_high & act_high & pend_high) != '0);
  cov_read_high: cover property (rd_ps_high ##1 (|hrdata_o));
  cov_set_vs_clr: cover property (wr_pc_mid && (irq_mid & wd_mid) != '0);
  cov_clr_enable: cover property (wr_ec_high && wd_high != '0);

endmodule : interrupt_pend_set_upper

/* File: interrupt_pend_set_upper_bench.sv */
// self-checking bench for the upper pending-set block over its bus
`timescale 1ns/10ps
`include "pend_set_consts.svh"

module interrupt_pend_set_upper_bench;
  import pend_set_pkg::*;

  logic                 clk_i;
  logic                 rst_i;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  logic [`ALL_BITS-1:0] irq;
  logic [`ALL_BITS-1:0] active;
  logic [`ALL_BITS-1:0] pending;
  logic [`ALL_BITS-1:0] enabled;
  logic [31:0]          rd;
  logic [31:0]          mask;
  int                   fails;
  int                   n_checks;

  // single slave, so its ready is the bus ready
  interrupt_pend_set_upper DUT (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .hsel_i      (hsel),
    .haddr_i     (haddr),
    .htrans_i    (htrans),
    .hwrite_i    (hwrite),
    .hsize_i     (hsize),
    .hready_i    (hreadyout),
    .hwdata_i    (hwdata),
    .hrdata_o    (hrdata),
    .hreadyout_o (hreadyout),
    .hresp_o     (hresp),
    .irq_i       (irq),
    .active_i    (active),
    .pending_o   (pending),
    .enabled_o   (enabled)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // no wait count is assumed; a stuck ready is a mismatch
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk_i);
    while (hreadyout !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n == 16)
    begin
      fails++;
      $display("[FAIL] %0t bus ready never came", $time);
    end
  endtask : wait_ready

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, input logic [2:0] sz);
    hsel   <= 1'b1;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    hsize  <= sz;
    htrans <= `HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, `HSIZE_WORD);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000, `HSIZE_WORD);
    check(rd, exp);
    check({31'h00000000, hresp}, 32'h00000000);
  endtask : rd_chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    tally_and_finish();
  end

  initial
  begin
    rst_i = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `HSIZE_WORD;
    hwdata = 32'h00000000;
    irq = '0;
    active = '0;
    fails = 0;
    n_checks = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`OFF_PS_MID, 32'h00000000);
    rd_chk(`OFF_PS_HIGH, 32'h00000000);
    $display("test reset done");
    // everything starts disabled, so forced pends must not stick
    wr(`OFF_PS_MID, 32'hFFFFFFFF);
    wr(`OFF_PS_HIGH, 32'hFFFFFFFF);
    rd_chk(`OFF_PS_MID, 32'h00000000);
    rd_chk(`OFF_PS_HIGH, 32'h00000000);
    wr(`OFF_ES_MID, 32'hFFFFFFFF);
    wr(`OFF_ES_HIGH, 32'hFFFFFFFF);
    rd_chk(`OFF_ES_HIGH, 32'h00003FFF);
    $display("test disabled done");
    // byte-sized and unmapped writes are dropped
    xfer(1'b1, `OFF_PS_HIGH, 32'h00000001, 3'h0);
    rd_chk(`OFF_PS_HIGH, 32'h00000000);
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h00000000);
    $display("test refused done");
    mask = 32'h00000000;
    for (int n = 0; n < 32; n++)
    begin
      mask[n] = 1'b1;
      wr(`OFF_PS_MID, 32'h00000001 << n);
      rd_chk(`OFF_PS_MID, mask);
    end
    @(negedge clk_i);
    check(pending[31:0], mask);
    wr(`OFF_PS_HIGH, 32'hFFFFFFFF);
    rd_chk(`OFF_PS_HIGH, 32'h00003FFF);
    rd_chk(`OFF_PC_HIGH, 32'h00003FFF);
    $display("test set done");
    wr(`OFF_PC_MID, 32'h0000FFFF);
    rd_chk(`OFF_PS_MID, 32'hFFFF0000);
    rd_chk(`OFF_PC_MID, 32'hFFFF0000);
    wr(`OFF_PS_MID, 32'h00000000);
    rd_chk(`OFF_PS_MID, 32'hFFFF0000);
    // bit 16 is interrupt 48, held in service across the clear
    active <= 46'h000000010000;
    wr(`OFF_PC_MID, 32'hFFFFFFFF);
    active <= '0;
    rd_chk(`OFF_PS_MID, 32'h00010000);
    $display("test clear done");
    wr(`OFF_EC_HIGH, 32'h00000001);
    rd_chk(`OFF_ES_HIGH, 32'h00003FFE);
    wr(`OFF_PC_HIGH, 32'h00003FFF);
    wr(`OFF_PS_HIGH, 32'h00003FFF);
    rd_chk(`OFF_PS_HIGH, 32'h00003FFE);
    $display("test disable done");
    // a hardware request pends interrupt 64 even while disabled
    @(posedge clk_i);
    irq <= 46'h000100000000;
    @(posedge clk_i);
    irq <= '0;
    @(negedge clk_i);
    check({18'h00000, pending[45:32]}, 32'h00003FFF);
    $display("test hardware done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(negedge clk_i);
    check(pending[31:0], 32'h00000000);
    check({18'h00000, enabled[45:32]}, 32'h00000000);
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`OFF_ES_MID, 32'h00000000);
    $display("test second reset done");
    tally_and_finish();
  end

endmodule : interrupt_pend_set_upper_bench

/* File: pend_bank.sv */
// one bank of pending and enable flags
`timescale 1ns/10ps

module pend_bank #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // requests and service status, one bit per interrupt
  input  wire logic [W-1:0] hw_set_i,
  input  wire logic [W-1:0] sw_set_i,
  input  wire logic [W-1:0] sw_clr_i,
  input  wire logic [W-1:0] en_set_i,
  input  wire logic [W-1:0] en_clr_i,
  input  wire logic [W-1:0] active_i,
  // state
  output logic      [W-1:0] pend_o,
  output logic      [W-1:0] en_o
);

  // a software pend only lands on an enabled line; a serviced line
  // ignores a clear, and any set in the same cycle beats the clear
  wire [W-1:0] set_bits  = hw_set_i | (sw_set_i & en_o);
  wire [W-1:0] clr_bits  = sw_clr_i & ~active_i;
  wire [W-1:0] next_pend = (pend_o & ~clr_bits) | set_bits;
  wire [W-1:0] next_en   = (en_o & ~en_clr_i) | en_set_i;

  // pending state is undefined by contract; zero is simply convenient
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pend_o <= '0;
      en_o   <= '0;
    end
    else
    begin
      pend_o <= next_pend;
      en_o   <= next_en;
    end
  end

endmodule : pend_bank

/* File: pend_set_consts.svh */
// constants for the upper pending-set block and its register window
`ifndef PEND_SET_CONSTS_SVH
`define PEND_SET_CONSTS_SVH

`define WORD_BITS     32
`define MID_BITS      32
`define HIGH_BITS     14
`define ALL_BITS      46
`define FIRST_IRQ     32
`define ADDR_BITS     8

`define OFF_PS_MID    8'h00
`define OFF_PS_HIGH   8'h04
`define OFF_PC_MID    8'h08
`define OFF_PC_HIGH   8'h0C
`define OFF_ES_MID    8'h10
`define OFF_ES_HIGH   8'h14
`define OFF_EC_MID    8'h18
`define OFF_EC_HIGH   8'h1C

`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD    3'h2
`define HRESP_OKAY    1'h0
`define RDATA_RESET   32'h00000000

`endif

/* File: pend_set_pkg.sv */
// types shared by the pending-set block and its bus port
`include "pend_set_consts.svh"

package pend_set_pkg;

  typedef struct packed {
    logic                    valid;
    logic [`ADDR_BITS-1:0]   addr;
    logic [`WORD_BITS-1:0]   data;
  } reg_wr_t;

  typedef struct packed {
    logic                    valid;
    logic [`ADDR_BITS-1:0]   addr;
  } reg_rd_t;

endpackage : pend_set_pkg
